/* File: core/atc_clk_div.sv */
/*
  atc_clk_div: free-running divider giving a one-cycle conversion
  clock enable at pclk / 2**sel. Assumes reload pulses on writes.
*/
`timescale 1ns/1ps
module atc_clk_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [2:0] sel,
  input wire logic reload,
  output logic tick
);
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } atc_div_t;
  atc_div_t state_reg;
  atc_div_t state_next;
  logic [6:0] limit;

  // divide by 1,2,4..128 for codes 0..7, see RULE5
  assign limit = 7'((8'h01 << sel) - 8'h01);

  // reload on every field write so a new ratio starts clean, see RULE24
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (reload || !enable) begin
      state_next.cnt = limit;
    end else if (state_reg.cnt == 7'h00) begin
      state_next.cnt = limit;
      state_next.tick = 1'b1;
    end else begin
      state_next.cnt = state_reg.cnt - 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;
endmodule

/* File: core/atc_ctrl.sv */
/*
  atc_ctrl: APB register block and conversion sequencer for a 12-bit
  converter with a temperature sensor path. Assumes the analog
  converter presents its result on adc_data in the pclk domain.
*/
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
//Function
//RULE1 - auto mode restarts after each completion
//RULE2 - software reads result in completion handler
//RULE3 - cpu stalled while halt-mode conversion runs
//RULE4 - reference select: supply or pin
//RULE5 - clock divider 1 to 128
//RULE6 - software keeps sensor clock 500k-1M
//RULE7 - sensor ref or output sampled
//RULE8 - amp2 gain 4 or 5, resets 1
//RULE9 - amp1 gain 1.675 or unity
//RULE10 - software waits sensor settle time
//RULE11 - amp2 and amp1 power enables
//RULE12 - pos ref external select routing
//RULE13 - software keeps external select low
//RULE14 - amp2 bias select
//RULE15 - internal bits stay zero
//RULE16 - sensor clock 4, 8, 16 periods
//RULE17 - sensor conversion 5N plus 17 clocks
//RULE18 - amp1 input bandgap or ptat
//RULE19 - unimplemented bits read zero
//RULE20 - start on 0-1-0 start pulse
//RULE21 - busy set at start, cleared done
//RULE22 - completion raises interrupt request
//RULE23 - power off clears result
//RULE24 - divider reloaded on field write
module atc_ctrl #(
  parameter int EXT_TICKS = atc_pkg::EXT_CONV_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] adc_data,
  output logic conv_power,
  output logic [3:0] chan_sel,
  output logic conv_clk_en,
  output logic sensor_clk_en,
  output logic conv_active,
  output logic conv_done_irq,
  output logic cpu_stall,
  output logic [1:0] ref_sel,
  output logic sample_sensor_ref,
  output logic sample_sensor_out,
  output logic sensor_enable,
  output logic amp1_power_enable,
  output logic amp2_power_enable,
  output logic amp1_gain_sel,
  output logic amp2_gain_sel,
  output logic amp1_input_sel,
  output logic amp2_bias_sel
);
  typedef struct packed {
    logic start;
    logic power;
    logic fmt;
    logic [3:0] chan;
    logic auto_c;
    logic halt;
    logic refsrc;
    logic [2:0] ckdiv;
    logic ref_out_en;
    logic g2;
    logic g1;
    logic sens_on;
    logic op2;
    logic op1;
    logic vext;
    logic bias;
    logic [1:0] tsclk;
    logic vptat;
    logic busy;
    logic sens;
    logic [7:0] cnt;
    logic [4:0] tscnt;
    logic tsclk_en;
    logic [11:0] result;
    logic done;
    logic [31:0] rdata;
  } atc_state_t;

  atc_state_t state_reg;
  atc_state_t state_next;
  logic tick;
  logic wr;
  logic wr_a;
  logic wr_b;
  logic start_evt;
  logic [7:0] conv_len;
  logic [4:0] ratio;

  // sensor clock ratio, see RULE16
  function automatic logic [4:0] sens_ratio(input logic [1:0] s);
    if (s[1]) begin
      return atc_pkg::SENS_DIV2;
    end else if (s[0]) begin
      return atc_pkg::SENS_DIV1;
    end else begin
      return atc_pkg::SENS_DIV0;
    end
  endfunction

  // mapped word check, used only for the error answer; read data decodes its own case
  function automatic logic addr_hit(input logic [7:0] a);
    return a == atc_pkg::OFS_CTRL_A || a == atc_pkg::OFS_CTRL_B ||
      a == atc_pkg::OFS_SENS_GAIN || a == atc_pkg::OFS_SENS_EN ||
      a == atc_pkg::OFS_SENS_CLK || a == atc_pkg::OFS_SENS_AMP ||
      a == atc_pkg::OFS_RESULT;
  endfunction

  atc_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(state_reg.power),
    .sel(state_reg.ckdiv),
    .reload(wr_b),
    .tick(tick)
  );

  // zero-wait slave; error only on an unmapped word
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);
  assign wr = psel && penable && pwrite;
  assign wr_a = wr && paddr == atc_pkg::OFS_CTRL_A;
  assign wr_b = wr && paddr == atc_pkg::OFS_CTRL_B;
  // falling edge of the written start bit launches, see RULE20
  assign start_evt = wr_a && state_reg.start && !pwdata[atc_pkg::START_POS] && state_reg.power;
  assign ratio = sens_ratio(state_reg.tsclk);
  // sensor path takes 5N+17 clocks, see RULE17
  assign conv_len = state_reg.sens ? 8'(atc_pkg::SENS_MUL * int'(ratio) + atc_pkg::SENS_ADD) : 8'(EXT_TICKS);

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.tsclk_en = 1'b0;
    // register writes; unimplemented bits are never stored, see RULE19
    if (wr) begin
      case (paddr)
        atc_pkg::OFS_CTRL_A: begin
          state_next.start = pwdata[atc_pkg::START_POS];
          state_next.power = pwdata[atc_pkg::PWR_POS];
          state_next.fmt = pwdata[atc_pkg::FMT_POS];
          state_next.chan = pwdata[atc_pkg::CHAN_MSB:0];
        end
        atc_pkg::OFS_CTRL_B: begin
          state_next.auto_c = pwdata[atc_pkg::AUTO_POS];
          state_next.halt = pwdata[atc_pkg::HALT_POS];
          state_next.refsrc = pwdata[atc_pkg::REFSRC_POS];
          state_next.ckdiv = pwdata[atc_pkg::CKDIV_MSB:0];
        end
        atc_pkg::OFS_SENS_GAIN: begin
          state_next.ref_out_en = pwdata[atc_pkg::REFOUT_POS];
          state_next.g2 = pwdata[atc_pkg::G2_POS];
          state_next.g1 = pwdata[atc_pkg::G1_POS];
        end
        atc_pkg::OFS_SENS_EN: begin
          state_next.sens_on = pwdata[atc_pkg::SENS_ON_POS];
          state_next.op2 = pwdata[atc_pkg::OP2_POS];
          state_next.op1 = pwdata[atc_pkg::OP1_POS];
        end
        // internal bits 5..2 are not stored and stay zero, see RULE15
        atc_pkg::OFS_SENS_CLK: begin
          state_next.vext = pwdata[atc_pkg::VEXT_POS];
          state_next.bias = pwdata[atc_pkg::BIAS_POS];
          state_next.tsclk = pwdata[atc_pkg::TSCLK_MSB:0];
        end
        atc_pkg::OFS_SENS_AMP: begin
          state_next.vptat = pwdata[atc_pkg::VPTAT_POS];
        end
        default: begin
        end
      endcase
    end
    // conversion sequencer
    if (!state_reg.power) begin
      // power off aborts and clears the result, see RULE23
      state_next.busy = 1'b0;
      state_next.cnt = atc_pkg::CNT_RST;
      state_next.result = 12'h000;
    end else if (start_evt && !state_reg.busy) begin
      // a start while busy is ignored rather than restarting
      state_next.busy = 1'b1; // see RULE21
      state_next.cnt = atc_pkg::CNT_RST;
      state_next.tscnt = 5'h00;
      state_next.sens = state_reg.sens_on && state_reg.chan[3];
    end else if (state_reg.busy && tick) begin
      if (state_reg.cnt == conv_len - 8'h01) begin
        state_next.done = 1'b1; // see RULE22
        state_next.result = adc_data;
        state_next.cnt = atc_pkg::CNT_RST;
        state_next.tscnt = 5'h00;
        // auto mode keeps busy and starts over, see RULE1
        state_next.busy = state_reg.auto_c; // see RULE21
      end else begin
        state_next.cnt = state_reg.cnt + 8'h01;
      end
      // sensor clock every ratio conversion clocks, see RULE16
      if (state_reg.sens && state_reg.cnt != conv_len - 8'h01) begin
        if (state_reg.tscnt == ratio - 5'h01) begin
          state_next.tscnt = 5'h00;
          state_next.tsclk_en = 1'b1;
        end else begin
          state_next.tscnt = state_reg.tscnt + 5'h01;
        end
      end
    end
    // read data captured in setup so it is steady in access
    if (psel && !penable && !pwrite) begin
      case (paddr)
        atc_pkg::OFS_CTRL_A: begin
          state_next.rdata = {24'h0, state_reg.start, state_reg.busy, state_reg.power, state_reg.fmt, state_reg.chan};
        end
        atc_pkg::OFS_CTRL_B: begin
          state_next.rdata = {24'h0, state_reg.auto_c, 1'b0, state_reg.halt, state_reg.refsrc, 1'b0, state_reg.ckdiv};
        end
        atc_pkg::OFS_SENS_GAIN: begin
          state_next.rdata = {24'h0, state_reg.ref_out_en, state_reg.g2, state_reg.g1, 5'h00};
        end
        atc_pkg::OFS_SENS_EN: begin
          state_next.rdata = {24'h0, state_reg.sens_on, state_reg.op2, state_reg.op1, 5'h00};
        end
        atc_pkg::OFS_SENS_CLK: begin
          state_next.rdata = {24'h0, state_reg.vext, state_reg.bias, 4'h0, state_reg.tsclk};
        end
        atc_pkg::OFS_SENS_AMP: begin
          state_next.rdata = {24'h0, 2'h0, state_reg.vptat, 5'h00};
        end
        atc_pkg::OFS_RESULT: begin
          state_next.rdata = state_reg.fmt ? {20'h0, state_reg.result} : {16'h0, state_reg.result, 4'h0};
        end
        default: begin
          state_next.rdata = 32'h0;
        end
      endcase
    end
  end

  // all state in one register; amp2 gain powers up at 1, see RULE8
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.g2 <= atc_pkg::G2_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign conv_power = state_reg.power;
  assign chan_sel = state_reg.chan;
  assign conv_clk_en = tick;
  assign sensor_clk_en = state_reg.tsclk_en;
  assign conv_active = state_reg.busy;
  assign conv_done_irq = state_reg.done;
  // cpu held only while a halt-mode conversion is running, see RULE3
  assign cpu_stall = state_reg.halt && state_reg.busy;
  // reference: sensor ref unless external select hands it over, see RULE12
  assign ref_sel = !state_reg.vext ? atc_pkg::REF_TSVREF : state_reg.refsrc ? atc_pkg::REF_PIN : atc_pkg::REF_SUPPLY; // see RULE4
  // channel 1xxx with sensor on picks ref or output, see RULE7
  assign sample_sensor_ref = state_reg.sens_on && state_reg.chan[3] && state_reg.ref_out_en;
  assign sample_sensor_out = state_reg.sens_on && state_reg.chan[3] && !state_reg.ref_out_en;
  assign sensor_enable = state_reg.sens_on;
  assign amp1_power_enable = state_reg.op1; // see RULE11
  assign amp2_power_enable = state_reg.op2; // see RULE11
  assign amp1_gain_sel = state_reg.g1; // see RULE9
  assign amp2_gain_sel = state_reg.g2; // see RULE8
  assign amp1_input_sel = state_reg.vptat; // see RULE18
  assign amp2_bias_sel = state_reg.bias; // see RULE14

  // helper: conversion clocks seen since the last start or completion
  logic [7:0] a_ticks;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_ticks <= 8'h00;
    end else if (!state_reg.busy || state_reg.done) begin
      a_ticks <= 8'(tick && state_reg.busy);
    end else if (tick) begin
      a_ticks <= a_ticks + 8'h01;
    end
  end

  property p_auto_restart;
    @(posedge pclk) disable iff (!presetn)
    state_reg.done && $past(state_reg.auto_c) && state_reg.power |-> state_reg.busy;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("auto mode did not keep converting"); // see RULE1

  property p_stall;
    @(posedge pclk) disable iff (!presetn)
    $fell(cpu_stall) && state_reg.halt && state_reg.power |-> conv_done_irq;
  endproperty
  a_stall: assert property (p_stall) else $error("cpu released before conversion end"); // see RULE3

  property p_ref_sel;
    @(posedge pclk) disable iff (!presetn)
    state_reg.vext |-> ref_sel == (state_reg.refsrc ? atc_pkg::REF_PIN : atc_pkg::REF_SUPPLY);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference select wrong"); // see RULE4

  property p_div2;
    @(posedge pclk) disable iff (!presetn)
    tick && state_reg.ckdiv == 3'h1 && !wr_b && state_reg.power ##1 !wr_b && state_reg.power |-> !tick ##1 tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two spacing wrong"); // see RULE5

  property p_sens_sample;
    @(posedge pclk) disable iff (!presetn)
    state_reg.busy && state_reg.sens && state_reg.ref_out_en |-> sample_sensor_ref && !sample_sensor_out;
  endproperty
  a_sens_sample: assert property (p_sens_sample) else $error("sensor sample select wrong"); // see RULE7

  property p_rsvd_zero;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && paddr == atc_pkg::OFS_SENS_CLK |-> prdata[5:2] == 4'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("internal bits not zero"); // see RULE15

  property p_sens_len;
    @(posedge pclk) disable iff (!presetn)
    $rose(state_reg.done) && state_reg.sens |-> a_ticks == 8'(atc_pkg::SENS_MUL * int'(ratio) + atc_pkg::SENS_ADD);
  endproperty
  a_sens_len: assert property (p_sens_len) else $error("sensor conversion length wrong"); // see RULE17

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    start_evt && !state_reg.busy |=> state_reg.busy;
  endproperty
  a_start: assert property (p_start) else $error("start pulse did not begin conversion"); // see RULE20

  property p_busy_clear;
    @(posedge pclk) disable iff (!presetn)
    state_reg.done && !$past(state_reg.auto_c) |-> !state_reg.busy;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared at completion"); // see RULE21

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    $fell(state_reg.busy) && state_reg.power |-> conv_done_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no completion request"); // see RULE22

  property p_power_clear;
    @(posedge pclk) disable iff (!presetn)
    !state_reg.power |=> state_reg.result == 12'h000;
  endproperty
  a_power_clear: assert property (p_power_clear) else $error("result kept with power off"); // see RULE23

  property p_unimpl;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && paddr == atc_pkg::OFS_CTRL_B |-> prdata[6] == 1'b0 && prdata[3] == 1'b0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit read nonzero"); // see RULE19

  property p_cov_auto;
    @(posedge pclk) disable iff (!presetn)
    state_reg.done && state_reg.auto_c;
  endproperty
  c_cov_auto: cover property (p_cov_auto);

  property p_cov_sens;
    @(posedge pclk) disable iff (!presetn)
    state_reg.done && state_reg.sens;
  endproperty
  c_cov_sens: cover property (p_cov_sens);

  property p_cov_stall;
    @(posedge pclk) disable iff (!presetn)
    $fell(cpu_stall);
  endproperty
  c_cov_stall: cover property (p_cov_stall);
endmodule

/* File: dv/test_adc_tsensor_control_regs.sv */
/*
  test_adc_tsensor_control_regs: self-checking bench for atc_ctrl, driven over APB.
  Assumes a zero-wait APB slave and EXT_TICKS shortened to 4 conversion clocks.
*/
`timescale 1ns/1ps
module test_adc_tsensor_control_regs;
  localparam int EXT = 4;
  localparam int SETTLE_CYC = 100; // sensor settle wait in clocks, arbitrary
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] adc_data = 12'h000;
  logic [31:0] prdata;
  logic [3:0] chan_sel;
  logic [1:0] ref_sel;
  logic pready, pslverr, conv_power, conv_clk_en, conv_active, conv_done_irq, cpu_stall;
  logic sample_sensor_ref, sample_sensor_out, sensor_enable, amp1_power_enable, amp2_power_enable;
  logic amp1_gain_sel, amp2_gain_sel, amp1_input_sel, amp2_bias_sel;
  logic sensor_clk_en;
  logic [8:0] lv;
  logic [7:0] ofs [5];
  logic [7:0] rstv [5];
  logic [7:0] msk [5];
  logic [32:0] exp_rd [$];
  int exp_len [$];
  int n_fail = 0;
  int comparisons = 0;
  int ticks = 0;
  int n_done = 0;
  int sn = 4;

  atc_ctrl #(.EXT_TICKS(EXT)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_data(adc_data),
    .conv_power(conv_power), .chan_sel(chan_sel), .conv_clk_en(conv_clk_en), .sensor_clk_en(sensor_clk_en),
    .conv_active(conv_active), .conv_done_irq(conv_done_irq), .cpu_stall(cpu_stall), .ref_sel(ref_sel),
    .sample_sensor_ref(sample_sensor_ref), .sample_sensor_out(sample_sensor_out),
    .sensor_enable(sensor_enable), .amp1_power_enable(amp1_power_enable),
    .amp2_power_enable(amp2_power_enable), .amp1_gain_sel(amp1_gain_sel), .amp2_gain_sel(amp2_gain_sel),
    .amp1_input_sel(amp1_input_sel), .amp2_bias_sel(amp2_bias_sel));

  // sensor-side levels packed for one-shot comparison
  assign lv = {sensor_enable, amp2_power_enable, amp1_power_enable, amp2_gain_sel, amp1_gain_sel,
               amp1_input_sel, amp2_bias_sel, ref_sel};

  always #10 pclk = ~pclk;

  task automatic final_report;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // scoreboard: reads judged at the access edge, lengths at each done pulse
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_rd.size() > 0) begin
      cmp({pslverr, prdata}, exp_rd.pop_front());
    end
    if (conv_done_irq === 1'b1) begin
      n_done++;
      cmp(33'(ticks), exp_len.size() > 0 ? 33'(exp_len.pop_front()) : 33'h1ffffffff);
      ticks = 0;
    end
    // sensor clock pulses land on whole multiples of the ratio
    if (sensor_clk_en === 1'b1) begin
      cmp(33'(ticks % sn), 33'h0);
    end
    if (conv_active === 1'b1 && conv_clk_en === 1'b1) begin
      ticks++;
    end
  end

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      cmp({32'h0, pready}, 33'h1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // let flop updates of the last edge land before looking
  task automatic settle;
    @(posedge pclk);
    #1;
  endtask

  task automatic wait_done(input int target);
    int n;
    n = 0;
    while (n_done < target && n < 8000) begin
      n++;
      @(posedge pclk);
    end
    if (n_done < target) cmp(33'h0, 33'h1);
  endtask

  // cycles between conversion clock pulses, minus one
  task automatic gap(output int n);
    n = 0;
    @(posedge pclk);
    while (conv_clk_en !== 1'b1 && n < 300) begin
      n++;
      @(posedge pclk);
    end
  endtask

  // full start pulse, busy read-back, then result in the chosen format
  task automatic conv(input logic [7:0] c, input int len);
    logic [11:0] v;
    v = 12'($urandom);
    adc_data <= v;
    exp_len.push_back(len);
    apb(1'b1, atc_pkg::OFS_CTRL_A, {24'h0, c | 8'h80});
    settle;
    cmp({32'h0, conv_active}, 33'h0);
    apb(1'b1, atc_pkg::OFS_CTRL_A, {24'h0, c});
    rd(atc_pkg::OFS_CTRL_A, {25'h0, c | 8'h40});
    wait_done(n_done + 1);
    rd(atc_pkg::OFS_RESULT, {1'b0, c[4] ? {20'h0, v} : {16'h0, v, 4'h0}});
  endtask

  initial begin
    int n;
    int base;
    logic [11:0] av;
    ofs = '{atc_pkg::OFS_CTRL_B, atc_pkg::OFS_SENS_GAIN, atc_pkg::OFS_SENS_EN,
            atc_pkg::OFS_SENS_CLK, atc_pkg::OFS_SENS_AMP};
    rstv = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    msk = '{8'hb7, 8'he0, 8'he0, 8'hc3, 8'h20};
    void'($urandom(32'hee7786b5));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    cmp({32'h0, amp2_gain_sel}, 33'h1);
    // reset values, then all-ones to find writable bits
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], {25'h0, rstv[i]});
      apb(1'b1, ofs[i], 32'hffffffff);
      rd(ofs[i], {25'h0, msk[i]});
    end
    settle;
    cmp({24'h0, lv}, {24'h0, 9'h1fe});
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ofs[i], 32'h0);
    end
    settle;
    cmp({24'h0, lv}, 33'h0);
    rd(8'h40, {1'b1, 32'h0});
    // reference routing: external select hands the choice over
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, atc_pkg::OFS_SENS_CLK, (i < 2) ? 32'h80 : 32'h00);
      apb(1'b1, atc_pkg::OFS_CTRL_B, (i > 0) ? 32'h10 : 32'h00);
      settle;
      cmp({31'h0, ref_sel}, (i < 2) ? 33'(i + 1) : 33'h0);
    end
    apb(1'b1, atc_pkg::OFS_SENS_CLK, 32'h0);
    apb(1'b1, atc_pkg::OFS_CTRL_A, 32'h20);
    // every divider code: period is 2**code system clocks
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, atc_pkg::OFS_CTRL_B, 32'(s));
      gap(n);
      gap(n);
      cmp(33'(n), 33'((1 << s) - 1));
    end
    apb(1'b1, atc_pkg::OFS_CTRL_B, 32'h01);
    conv(8'h23, EXT);
    conv(8'h30, EXT);
    // sensor path: settle wait, source pick, then every sensor clock code
    apb(1'b1, atc_pkg::OFS_SENS_EN, 32'h80);
    repeat (SETTLE_CYC) @(posedge pclk);
    apb(1'b1, atc_pkg::OFS_SENS_GAIN, 32'h80);
    apb(1'b1, atc_pkg::OFS_CTRL_A, 32'h28);
    settle;
    cmp({27'h0, sample_sensor_ref, sample_sensor_out, chan_sel}, {27'h0, 6'h28});
    apb(1'b1, atc_pkg::OFS_SENS_GAIN, 32'h00);
    settle;
    cmp({27'h0, sample_sensor_ref, sample_sensor_out, chan_sel}, {27'h0, 6'h18});
    // pclk / 64 puts the sensor conversion clock near 781 kHz
    apb(1'b1, atc_pkg::OFS_CTRL_B, 32'h06);
    for (int s = 0; s < 4; s++) begin
      sn = 4 << ((s > 1) ? 2 : s);
      apb(1'b1, atc_pkg::OFS_SENS_CLK, 32'(s)); // external select kept low
      apb(1'b1, atc_pkg::OFS_SENS_GAIN, (s % 2 == 1) ? 32'h80 : 32'h00);
      conv(8'h28, 5 * sn + 17);
    end
    // auto mode with cpu halt: three back-to-back conversions
    apb(1'b1, atc_pkg::OFS_SENS_EN, 32'h0);
    apb(1'b1, atc_pkg::OFS_CTRL_B, 32'ha1);
    av = 12'($urandom);
    adc_data <= av;
    base = n_done;
    repeat (3) exp_len.push_back(EXT);
    apb(1'b1, atc_pkg::OFS_CTRL_A, 32'ha0);
    apb(1'b1, atc_pkg::OFS_CTRL_A, 32'h20);
    wait_done(base + 1);
    rd(atc_pkg::OFS_RESULT, {17'h0, av, 4'h0}); // read only just after a completion
    settle;
    cmp({31'h0, conv_active, cpu_stall}, 33'h3);
    wait_done(base + 2);
    apb(1'b1, atc_pkg::OFS_CTRL_B, 32'h21);
    wait_done(base + 3);
    settle;
    settle;
    cmp({31'h0, conv_active, cpu_stall}, 33'h0);
    // power off wipes the result
    apb(1'b1, atc_pkg::OFS_CTRL_A, 32'h00);
    rd(atc_pkg::OFS_RESULT, 33'h0);
    settle;
    cmp({32'h0, conv_power}, 33'h0);
    final_report;
  end

  // watchdog: the whole sequence needs about 20k cycles
  initial begin
    #1000000;
    n_fail++;
    final_report;
  end
endmodule

/* File: inc/atc_pkg.sv */
/*
  atc_pkg: register offsets, field positions, reset values and
  timing figures of the converter and sensor control block.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package atc_pkg;
  // byte addresses of the register words
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_SENS_GAIN = 8'h08;
  localparam logic [7:0] OFS_SENS_EN = 8'h0c;
  localparam logic [7:0] OFS_SENS_CLK = 8'h10;
  localparam logic [7:0] OFS_SENS_AMP = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;
  // converter_control_a fields
  localparam int START_POS = 7;
  localparam int BUSY_POS = 6;
  localparam int PWR_POS = 5;
  localparam int FMT_POS = 4;
  localparam int CHAN_MSB = 3;
  // converter_control_b fields
  localparam int AUTO_POS = 7;
  localparam int HALT_POS = 5;
  localparam int REFSRC_POS = 4;
  localparam int CKDIV_MSB = 2;
  // sensor_ref_gain_control fields
  localparam int REFOUT_POS = 7;
  localparam int G2_POS = 6;
  localparam int G1_POS = 5;
  // sensor_enable_control fields
  localparam int SENS_ON_POS = 7;
  localparam int OP2_POS = 6;
  localparam int OP1_POS = 5;
  // sensor_ref_clock_control fields
  localparam int VEXT_POS = 7;
  localparam int BIAS_POS = 6;
  localparam int TSCLK_MSB = 1;
  // sensor_amp_input_control fields
  localparam int VPTAT_POS = 5;
  // reset values
  localparam logic CTRL_RST = 1'b0;
  localparam logic G2_RST = 1'b1;
  localparam logic [7:0] CNT_RST = 8'h00;
  // sensor conversion length: mul * ratio + add conversion clocks
  localparam int SENS_MUL = 5;
  localparam int SENS_ADD = 17;
  localparam logic [4:0] SENS_DIV0 = 5'h04;
  localparam logic [4:0] SENS_DIV1 = 5'h08;
  localparam logic [4:0] SENS_DIV2 = 5'h10;
  localparam int EXT_CONV_TICKS = 16;
  // reference routing codes
  localparam logic [1:0] REF_TSVREF = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_PIN = 2'h2;
endpackage
